// ==== design/pwf_fault_top.sv ====
// fault input handling for the four phase waveform timer
`include "pwf_consts.svh"

// Overview of operation
// - mode 0 leaves outputs and phases alone; events still reported.
// - mode 1 kills output, jumps to opposite dead phase, holds while high.
// - mode 1 input a acts in phase a on output a; resumes dead b.
// - mode 1 input b acts in phase b on output b; resumes dead a.
// - mode 2 kills output, runs opposite dead and on, then waits.
// - mode 2 early release skips the wait, opposite phases continue.
// - mode 2 each input acts only in its own phase and output.
// - mode 3 kills output and repeats opposite phases while fault stays.
// - mode 3 release finishes current phase; inputs act in own phase.
// - mode 4 either input blanks both outputs; phases keep running.
// - mode 5 blanks both; on phase jumps opposite; dead phases alternate.
// - mode 5 dead phase runs out; release finishes dead then normal.
// - mode 6 blanks both, jumps to dead, then next dead and waits; release finishes it.
// - mode 7 halts outputs and phases until a software restart.
// - mode 7 restart while high halts again; restart begins dead a.
// - mode 8 rising edge during own on phase jumps to opposite dead.
// - mode 9 rising edge during own on phase blanks rest of it.
// - mode 10 level blanks output; release mid on phase keeps it off.
module pwf_fault_top (
   // clock and reset
   input  wire logic               CLK_SYS,
   input  wire logic               RSTN,
   // timer control
   input  wire logic               TIMER_EN,
   input  wire logic               RESTART_CMD,
   input  wire pwf_pkg::pwf_mode_s FAULT_MODE_SELECT,
   input  wire pwf_pkg::pwf_len_s  PHASE_LEN,
   // fault event inputs, b in bit 1
   input  wire logic [1:0]         FAULT_EVT,
   // waveform outputs and status
   output logic                    WAVEFORM_OUT_A,
   output logic                    WAVEFORM_OUT_B,
   output pwf_pkg::pwf_phase_e     PHASE_NOW,
   output logic                    HALTED,
   output logic [1:0]              EVT_SEEN
);
   import pwf_pkg::*;

   // ----------------------------------------------------------------------
   // shared state
   // ----------------------------------------------------------------------
   logic [1:0] sync1_r;
   logic [1:0] lvl_r;
   logic [1:0] lvl_d_r;
   logic [1:0] rise;
   logic [1:0] jreq;
   logic [1:0] kill;
   logic [1:0] hold_i;
   logic [1:0] act4;
   logic [1:0] act5;
   logic [1:0] act6;
   logic [1:0] act7;
   logic [1:0] wait1_r;
   logic [1:0] wait2_r;
   logic [1:0] arm2_r;
   logic [1:0] arm3_r;
   logic [1:0] blk_r;
   pwf_phase_e jtgt [2];
   pwf_phase_e phase;
   pwf_phase_e jump_ph;
   logic       last;
   logic       halt_r;
   logic       halt_nxt;
   logic       wait6_r;
   logic       wait6_nxt;
   logic       wave_a_r;
   logic       wave_b_r;
   logic       any4;
   logic       any5;
   logic       any6;
   logic       any7;
   logic       hold_all;
   logic       jump_en;
   logic       in_on;
   logic       in_dead;
   logic       dead_end;
   logic       restart_ok;
   logic       j56;
   logic       both_off;
   pwf_phase_e opp_dead;
   pwf_phase_e other_dead;

   // ----------------------------------------------------------------------
   // input synchronisers and edge detect
   // ----------------------------------------------------------------------
   // active level after two flops, edge from a third
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         sync1_r <= 2'h0;
         lvl_r   <= 2'h0;
         lvl_d_r <= 2'h0;
      end else begin
         sync1_r <= FAULT_EVT;
         lvl_r   <= sync1_r;
         lvl_d_r <= lvl_r;
      end
   end
   assign rise = lvl_r & ~lvl_d_r;

   // ----------------------------------------------------------------------
   // per input mode decode
   // ----------------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < 2; i++) begin : g_in
         localparam pwf_phase_e OWN_DEAD = (i == 0) ? DEAD_PHASE_A : DEAD_PHASE_B;
         localparam pwf_phase_e OWN_ON   = (i == 0) ? ON_PHASE_A : ON_PHASE_B;
         localparam pwf_phase_e OPP_DEAD = (i == 0) ? DEAD_PHASE_B : DEAD_PHASE_A;
         localparam pwf_phase_e OPP_ON   = (i == 0) ? ON_PHASE_B : ON_PHASE_A;
         pwf_mode_t m;
         logic      trig;
         logic      own_on;
         logic      end_opp_on;
         logic      j1;
         logic      j2;
         logic      j3;
         logic      rep3;
         logic      j8;

         // each input reads its own mode field
         assign m          = (i == 0) ? FAULT_MODE_SELECT.sel_a : FAULT_MODE_SELECT.sel_b;
         assign trig       = lvl_r[i] && (phase == OWN_DEAD || phase == OWN_ON);
         assign own_on     = (phase == OWN_ON);
         assign end_opp_on = last && !hold_all && (phase == OPP_ON);
         // jump to opposite dead, wait flag parks it
         assign j1   = (m == `PWF_MODE_JUMP_WAIT) && trig && !wait1_r[i];
         // jump, unless already parked on own dead
         assign j2   = (m == `PWF_MODE_OPP_WAIT) && trig && !wait2_r[i];
         // trigger and repeat of opposite phases
         assign j3   = (m == `PWF_MODE_OPP_REP) && trig;
         assign rep3 = (m == `PWF_MODE_OPP_REP) && arm3_r[i] && lvl_r[i] && end_opp_on;
         assign j8   = (m == `PWF_MODE_EDGE_JUMP) && rise[i] && own_on;
         assign jreq[i] = j1 || j2 || j3 || rep3 || j8;
         assign jtgt[i] = OPP_DEAD;
         assign hold_i[i] = (wait1_r[i] || wait2_r[i]) && lvl_r[i];
         assign kill[i] = blk_r[i] || ((m == `PWF_MODE_LVL_BLK) && lvl_r[i]);
         assign act4[i] = (m == `PWF_MODE_ALL_OFF) && lvl_r[i];
         assign act5[i] = (m == `PWF_MODE_DEAD_ONLY) && lvl_r[i];
         assign act6[i] = (m == `PWF_MODE_ALL_WAIT) && lvl_r[i];
         assign act7[i] = (m == `PWF_MODE_SW_HALT) && lvl_r[i];

         always_ff @(posedge CLK_SYS or negedge RSTN) begin
            if (!RSTN) begin
               wait1_r[i] <= 1'b0;
               wait2_r[i] <= 1'b0;
               arm2_r[i]  <= 1'b0;
               arm3_r[i]  <= 1'b0;
               blk_r[i]   <= 1'b0;
            end else begin
               wait1_r[i] <= (m == `PWF_MODE_JUMP_WAIT) && lvl_r[i] && (trig || wait1_r[i]);
               // arm stays until opposite on ends; early release means no wait
               arm2_r[i]  <= (m == `PWF_MODE_OPP_WAIT) && (j2 || (arm2_r[i] && !end_opp_on));
               // park on own dead after opposite on phase
               wait2_r[i] <= (m == `PWF_MODE_OPP_WAIT) && lvl_r[i]
                             && ((arm2_r[i] && end_opp_on) || wait2_r[i]);
               // release drops the repeat, current phase runs out
               arm3_r[i]  <= (m == `PWF_MODE_OPP_REP) && lvl_r[i] && (trig || arm3_r[i]);
               // blank until own on phase ends
               blk_r[i]   <= own_on && (blk_r[i]
                             || ((m == `PWF_MODE_EDGE_BLK) && rise[i])
                             || ((m == `PWF_MODE_LVL_BLK) && lvl_r[i]));
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------------
   // shared mode decode and phase steering
   // ----------------------------------------------------------------------
   assign any4       = |act4;
   assign any5       = |act5;
   assign any6       = |act6;
   assign any7       = |act7;
   assign in_on      = (phase == ON_PHASE_A) || (phase == ON_PHASE_B);
   assign in_dead    = !in_on;
   assign dead_end   = in_dead && last && !hold_all;
   assign opp_dead   = (phase == ON_PHASE_A) ? DEAD_PHASE_B : DEAD_PHASE_A;
   assign other_dead = (phase == DEAD_PHASE_A) ? DEAD_PHASE_B : DEAD_PHASE_A;
   // restart only lands when the input has dropped
   assign restart_ok = halt_r && RESTART_CMD && !any7;
   // on phase jumps, dead end redirects
   assign j56        = ((any5 || any6) && in_on) || ((any5 || any6) && dead_end);
   assign jump_en    = restart_ok || j56 || (|jreq);
   assign jump_ph    = restart_ok ? DEAD_PHASE_A :
                       (j56 && in_on) ? opp_dead :
                       j56     ? other_dead :
                       jreq[0] ? jtgt[0] : jtgt[1];
   assign hold_all   = halt_r || any7 || (wait6_r && any6) || (|hold_i);
   // wait starts at a dead end while active
   assign wait6_nxt  = any6 && (dead_end || wait6_r);
   assign halt_nxt   = any7 || (halt_r && !RESTART_CMD);
   assign both_off   = any4 || any5 || any6 || any7 || halt_r;

   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         halt_r   <= 1'b0;
         wait6_r  <= 1'b0;
         wave_a_r <= 1'b0;
         wave_b_r <= 1'b0;
      end else begin
         halt_r   <= halt_nxt;
         wait6_r  <= wait6_nxt;
         wave_a_r <= TIMER_EN && (phase == ON_PHASE_A) && !both_off && !kill[0];
         wave_b_r <= TIMER_EN && (phase == ON_PHASE_B) && !both_off && !kill[1];
      end
   end

   pwf_phase_seq u_seq (
      .clk     (CLK_SYS),
      .rstn    (RSTN),
      .en      (TIMER_EN),
      .hold    (hold_all),
      .jump_en (jump_en),
      .jump_ph (jump_ph),
      .len     (PHASE_LEN),
      .phase   (phase),
      .last    (last)
   );

   // ----------------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------------
   assign WAVEFORM_OUT_A = wave_a_r;
   assign WAVEFORM_OUT_B = wave_b_r;
   assign PHASE_NOW      = phase;
   assign HALTED         = halt_r;
   // synced level leaves for capture and interrupt logic in every mode
   assign EVT_SEEN       = lvl_r;

   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RSTN);

   logic b_quiet;
   assign b_quiet = (FAULT_MODE_SELECT.sel_b == `PWF_MODE_NONE) && !halt_r && TIMER_EN;

   sequence s_pin_up;
      !FAULT_EVT[0] ##1 FAULT_EVT[0] [*3];
   endsequence
   sequence s_a_trig(pwf_mode_t md);
      b_quiet && FAULT_MODE_SELECT.sel_a == md && lvl_r[0]
      && (phase == DEAD_PHASE_A || phase == ON_PHASE_A);
   endsequence

   chk_sync_two_flops: assert property (s_pin_up |-> lvl_r[0] && rise[0])
      else $error("event level not seen two cycles after pin rise");
   chk_m1_jump_dtb: assert property (s_a_trig(`PWF_MODE_JUMP_WAIT) |=> phase == DEAD_PHASE_B)
      else $error("mode 1 did not jump to dead b");
   chk_m1_parked: assert property (b_quiet && wait1_r[0] && lvl_r[0] && !jreq[0]
      |=> $stable(phase))
      else $error("mode 1 counter moved while parked");
   chk_m4_both_off: assert property (any4 |=> !WAVEFORM_OUT_A && !WAVEFORM_OUT_B)
      else $error("mode 4 left an output on");
   chk_m5_dead_alt: assert property (b_quiet && any5 && phase == DEAD_PHASE_A && dead_end
      && !any7 |=> phase == DEAD_PHASE_B)
      else $error("mode 5 dead phases not alternating");
   chk_m6_wait_hold: assert property (wait6_r && any6 && !halt_r && !any7 && TIMER_EN
      |=> $stable(phase))
      else $error("mode 6 counter moved while waiting");
   chk_m7_halt_off: assert property (any7 |=> halt_r ##0 !WAVEFORM_OUT_A && !WAVEFORM_OUT_B)
      else $error("mode 7 did not halt");
   chk_m7_restart_dta: assert property (restart_ok && TIMER_EN
      |=> phase == DEAD_PHASE_A && !halt_r)
      else $error("restart did not begin at dead a");
   chk_m7_rehalt: assert property (halt_r && RESTART_CMD && any7 |=> halt_r)
      else $error("restart with input high did not halt again");
   chk_m8_edge_jump: assert property (b_quiet && FAULT_MODE_SELECT.sel_a == `PWF_MODE_EDGE_JUMP
      && rise[0] && phase == ON_PHASE_A && !any7 |=> phase == DEAD_PHASE_B)
      else $error("mode 8 edge did not jump to dead b");
   chk_m9_block_rest: assert property (blk_r[0] && phase == ON_PHASE_A |=> !WAVEFORM_OUT_A)
      else $error("blocked on phase drove output a");
   chk_m10_level_off: assert property (FAULT_MODE_SELECT.sel_a == `PWF_MODE_LVL_BLK && lvl_r[0]
      |=> !WAVEFORM_OUT_A)
      else $error("mode 10 level left output a on");

endmodule // pwf_fault_top

// ==== design/pwf_consts.svh ====
// fault input mode codes and timing constants for the fault handling block
`ifndef PWF_CONSTS_SVH
`define PWF_CONSTS_SVH

// ----------------------------------------------------------------------
// fault mode field values
// ----------------------------------------------------------------------
`define PWF_MODE_NONE      4'h0
`define PWF_MODE_JUMP_WAIT 4'h1
`define PWF_MODE_OPP_WAIT  4'h2
`define PWF_MODE_OPP_REP   4'h3
`define PWF_MODE_ALL_OFF   4'h4
`define PWF_MODE_DEAD_ONLY 4'h5
`define PWF_MODE_ALL_WAIT  4'h6
`define PWF_MODE_SW_HALT   4'h7
`define PWF_MODE_EDGE_JUMP 4'h8
`define PWF_MODE_EDGE_BLK  4'h9
`define PWF_MODE_LVL_BLK   4'ha

// ----------------------------------------------------------------------
// field widths and reset values
// ----------------------------------------------------------------------
`define PWF_LEN_W          12
`define PWF_CNT_RST        12'h000

`endif

// ==== design/pwf_pkg.sv ====
// types shared by the fault handling block and its phase sequencer
package pwf_pkg;

   // gray coded along the normal dead a, on a, dead b, on b path
   typedef enum logic [1:0] {
      DEAD_PHASE_A = 2'b00,
      ON_PHASE_A   = 2'b01,
      DEAD_PHASE_B = 2'b11,
      ON_PHASE_B   = 2'b10
   } pwf_phase_e;

   typedef logic [11:0] pwf_len_t;
   typedef logic [3:0]  pwf_mode_t;

   typedef struct packed {
      pwf_len_t dead_a;
      pwf_len_t on_a;
      pwf_len_t dead_b;
      pwf_len_t on_b;
   } pwf_len_s;

   typedef struct packed {
      pwf_mode_t sel_b;
      pwf_mode_t sel_a;
   } pwf_mode_s;

endpackage : pwf_pkg

// ==== design/pwf_phase_seq.sv ====
// four phase sequencer with jump and hold controls
`include "pwf_consts.svh"

module pwf_phase_seq (
   // clock and reset
   input  wire logic               clk,
   input  wire logic               rstn,
   // control
   input  wire logic               en,
   input  wire logic               hold,
   input  wire logic               jump_en,
   input  wire pwf_pkg::pwf_phase_e jump_ph,
   input  wire pwf_pkg::pwf_len_s  len,
   // state
   output pwf_pkg::pwf_phase_e     phase,
   output logic                    last
);
   import pwf_pkg::*;

   pwf_phase_e phase_r;
   pwf_phase_e phase_nxt;
   pwf_phase_e next_ph;
   pwf_len_t   cnt_r;
   pwf_len_t   cnt_nxt;
   pwf_len_t   cur_len;

   // ----------------------------------------------------------------------
   // length select and natural successor
   // ----------------------------------------------------------------------
   assign cur_len = (phase_r == DEAD_PHASE_A) ? len.dead_a :
                    (phase_r == ON_PHASE_A)   ? len.on_a   :
                    (phase_r == DEAD_PHASE_B) ? len.dead_b : len.on_b;
   assign last    = (cnt_r == cur_len);
   assign phase   = phase_r;

   always_comb begin
      case (phase_r)
         DEAD_PHASE_A: next_ph = ON_PHASE_A;
         ON_PHASE_A:   next_ph = DEAD_PHASE_B;
         DEAD_PHASE_B: next_ph = ON_PHASE_B;
         ON_PHASE_B:   next_ph = DEAD_PHASE_A;
         default:      next_ph = DEAD_PHASE_A;
      endcase
   end

   // jump wins over hold so a wait always parks at the new phase start
   assign phase_nxt = !en     ? DEAD_PHASE_A :
                      jump_en ? jump_ph :
                      hold    ? phase_r :
                      last    ? next_ph : phase_r;
   assign cnt_nxt   = (!en || jump_en || (!hold && last)) ? `PWF_CNT_RST :
                      hold ? cnt_r : cnt_r + 12'h001;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         phase_r <= DEAD_PHASE_A;
         cnt_r   <= `PWF_CNT_RST;
      end else begin
         phase_r <= phase_nxt;
         cnt_r   <= cnt_nxt;
      end
   end

endmodule // pwf_phase_seq

// ==== testbench/pwf_evt_src.sv ====
// event routing network model that feeds the two fault event lines
module pwf_evt_src (
   // clock
   input  wire logic       clk,
   // requested event levels and pacing
   input  wire logic [1:0] req,
   input  wire logic       slow,
   // event lines toward the timer
   output logic [1:0]      evt
);
   timeunit 1ns;
   timeprecision 100ps;

   logic [1:0] req_r;

   initial begin
      req_r = 2'h0;
      evt   = 2'h0;
   end

   // active high, idle low
   // slow pacing adds one cycle, as a longer routing path would
   always @(posedge clk) begin
      req_r <= req;
      evt   <= slow ? req_r : req;
   end
endmodule // pwf_evt_src

// ==== testbench/pwf_fault_top_tb.sv ====
// self-checking bench for the fault input handling block
`include "pwf_consts.svh"

module pwf_fault_top_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import pwf_pkg::*;

   logic       CLK_SYS, RSTN, TIMER_EN, RESTART_CMD, evt_slow;
   logic       WAVEFORM_OUT_A, WAVEFORM_OUT_B, HALTED;
   logic [1:0] evt_req, EVT_SEEN;
   wire  [1:0] FAULT_EVT;
   pwf_mode_s  FAULT_MODE_SELECT;
   pwf_len_s   PHASE_LEN;
   pwf_phase_e PHASE_NOW;
   int         n_mismatch = 0;
   int         checks_done = 0;

   pwf_fault_top dut (.CLK_SYS(CLK_SYS), .RSTN(RSTN), .TIMER_EN(TIMER_EN),
      .RESTART_CMD(RESTART_CMD), .FAULT_MODE_SELECT(FAULT_MODE_SELECT),
      .PHASE_LEN(PHASE_LEN), .FAULT_EVT(FAULT_EVT), .WAVEFORM_OUT_A(WAVEFORM_OUT_A),
      .WAVEFORM_OUT_B(WAVEFORM_OUT_B), .PHASE_NOW(PHASE_NOW), .HALTED(HALTED),
      .EVT_SEEN(EVT_SEEN));

   pwf_evt_src u_src (.clk(CLK_SYS), .req(evt_req), .slow(evt_slow), .evt(FAULT_EVT));

   // ----------------------------------------------------------------------
   // shared helpers
   // ----------------------------------------------------------------------
   task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   task automatic chk_ph(input pwf_phase_e exp);
      chk("phase", {2'b00, exp}, {2'b00, PHASE_NOW});
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge CLK_SYS);
   endtask

   // bounded wait for the first cycle of phase p
   task automatic enter(input pwf_phase_e p);
      int i;
      i = 0;
      while (PHASE_NOW === p && i < 200) begin
         cyc(1);
         i++;
      end
      while (PHASE_NOW !== p && i < 400) begin
         cyc(1);
         i++;
      end
      chk_ph(p);
   endtask

   task automatic set_mode(input pwf_mode_t b, input pwf_mode_t a);
      FAULT_MODE_SELECT = {b, a};
   endtask

   // release events, return to mode 0 and let the sync pipe drain
   task automatic idle(input string name);
      evt_req = 2'b00;
      set_mode(`PWF_MODE_NONE, `PWF_MODE_NONE);
      cyc(8);
      $display("test %s done", name);
   endtask

   task automatic end_sim;
      $display("counts: %0d checks, %0d mismatches", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------------
   task automatic t_mode0;
      set_mode(`PWF_MODE_NONE, `PWF_MODE_NONE);
      enter(ON_PHASE_A);
      evt_req = 2'b11;
      cyc(4);
      chk("evt seen", 4'h3, {2'b00, EVT_SEEN});
      cyc(3);
      chk("out a", 4'h1, {3'b000, WAVEFORM_OUT_A});
      enter(DEAD_PHASE_B);
      idle("mode0");
   endtask

   task automatic t_mode1;
      set_mode(`PWF_MODE_NONE, `PWF_MODE_JUMP_WAIT);
      enter(ON_PHASE_B);
      evt_req = 2'b01;
      cyc(4);
      evt_req = 2'b00;
      cyc(3);
      chk_ph(ON_PHASE_B);
      enter(ON_PHASE_A);
      evt_req = 2'b01;
      cyc(5);
      chk_ph(DEAD_PHASE_B);
      chk("out a", 4'h0, {3'b000, WAVEFORM_OUT_A});
      cyc(30);
      chk_ph(DEAD_PHASE_B);
      evt_req = 2'b00;
      enter(ON_PHASE_B);
      set_mode(`PWF_MODE_JUMP_WAIT, `PWF_MODE_NONE);
      enter(ON_PHASE_B);
      evt_req = 2'b10;
      cyc(5);
      chk_ph(DEAD_PHASE_A);
      chk("out b", 4'h0, {3'b000, WAVEFORM_OUT_B});
      cyc(30);
      chk_ph(DEAD_PHASE_A);
      evt_req = 2'b00;
      enter(ON_PHASE_A);
      idle("mode1");
   endtask

   task automatic t_mode2;
      set_mode(`PWF_MODE_NONE, `PWF_MODE_OPP_WAIT);
      enter(ON_PHASE_A);
      evt_req = 2'b01;
      cyc(6);
      chk_ph(DEAD_PHASE_B);
      cyc(60);
      chk_ph(DEAD_PHASE_A);
      chk("out a", 4'h0, {3'b000, WAVEFORM_OUT_A});
      evt_req = 2'b00;
      enter(ON_PHASE_A);
      enter(ON_PHASE_A);
      evt_req = 2'b01;
      cyc(6);
      chk_ph(DEAD_PHASE_B);
      evt_req = 2'b00;
      cyc(20);
      chk_ph(ON_PHASE_A);
      idle("mode2");
   endtask

   task automatic t_mode3;
      logic bad;
      bad = 1'b0;
      set_mode(`PWF_MODE_NONE, `PWF_MODE_OPP_REP);
      enter(ON_PHASE_A);
      evt_req = 2'b01;
      cyc(6);
      repeat (40) begin
         bad = bad | ~PHASE_NOW[1] | WAVEFORM_OUT_A;
         cyc(1);
      end
      chk("phase a during fault", 4'h0, {3'b000, bad});
      evt_req = 2'b00;
      enter(ON_PHASE_A);
      idle("mode3");
   endtask

   task automatic t_mode4;
      logic       outs;
      logic       seen_on;
      outs = 1'b0;
      seen_on = 1'b0;
      evt_slow = 1'b1;
      set_mode(`PWF_MODE_ALL_OFF, `PWF_MODE_ALL_OFF);
      evt_req = 2'b10;
      cyc(7);
      repeat (40) begin
         outs = outs | WAVEFORM_OUT_A | WAVEFORM_OUT_B;
         seen_on = seen_on | (PHASE_NOW == ON_PHASE_A);
         cyc(1);
      end
      chk("outs during event", 4'h0, {3'b000, outs});
      chk("phases running", 4'h1, {3'b000, seen_on});
      evt_slow = 1'b0;
      idle("mode4");
   endtask

   task automatic t_mode5;
      logic       bad;
      logic [1:0] seen;
      bad = 1'b0;
      seen = 2'b00;
      set_mode(`PWF_MODE_NONE, `PWF_MODE_DEAD_ONLY);
      evt_req = 2'b01;
      cyc(6);
      repeat (64) begin
         bad = bad | PHASE_NOW[1] ^ PHASE_NOW[0] | WAVEFORM_OUT_A | WAVEFORM_OUT_B;
         seen = seen | {PHASE_NOW == DEAD_PHASE_B, PHASE_NOW == DEAD_PHASE_A};
         cyc(1);
      end
      chk("on phase or output", 4'h0, {3'b000, bad});
      chk("dead phases", 4'h3, {2'b00, seen});
      evt_req = 2'b00;
      enter(ON_PHASE_A);
      idle("mode5");
   endtask

   task automatic t_mode6;
      pwf_phase_e ph;
      set_mode(`PWF_MODE_ALL_WAIT, `PWF_MODE_ALL_WAIT);
      enter(ON_PHASE_A);
      evt_req = 2'b01;
      cyc(6);
      chk_ph(DEAD_PHASE_B);
      cyc(30);
      ph = PHASE_NOW;
      chk("dead wait", 4'h0, {3'b000, ph[1] ^ ph[0]});
      cyc(10);
      chk_ph(ph);
      chk("outs", 4'h0, {2'b00, WAVEFORM_OUT_A, WAVEFORM_OUT_B});
      evt_req = 2'b00;
      enter(ON_PHASE_A);
      idle("mode6");
   endtask

   task automatic t_mode7;
      pwf_phase_e ph;
      set_mode(`PWF_MODE_SW_HALT, `PWF_MODE_NONE);
      evt_req = 2'b10;
      cyc(5);
      chk("halted", 4'h1, {3'b000, HALTED});
      ph = PHASE_NOW;
      cyc(20);
      chk_ph(ph);
      chk("outs", 4'h0, {2'b00, WAVEFORM_OUT_A, WAVEFORM_OUT_B});
      RESTART_CMD = 1'b1;
      cyc(1);
      RESTART_CMD = 1'b0;
      cyc(3);
      chk("halted", 4'h1, {3'b000, HALTED});
      evt_req = 2'b00;
      cyc(5);
      RESTART_CMD = 1'b1;
      cyc(1);
      RESTART_CMD = 1'b0;
      chk("halted", 4'h0, {3'b000, HALTED});
      chk_ph(DEAD_PHASE_A);
      idle("mode7");
   endtask

   task automatic t_mode8;
      set_mode(`PWF_MODE_EDGE_JUMP, `PWF_MODE_NONE);
      enter(ON_PHASE_B);
      evt_req = 2'b10;
      cyc(5);
      chk_ph(DEAD_PHASE_A);
      chk("out b", 4'h0, {3'b000, WAVEFORM_OUT_B});
      idle("mode8");
   endtask

   task automatic t_mode9;
      set_mode(`PWF_MODE_NONE, `PWF_MODE_EDGE_BLK);
      enter(ON_PHASE_A);
      cyc(1);
      evt_req = 2'b01;
      cyc(6);
      chk("out a", 4'h0, {3'b000, WAVEFORM_OUT_A});
      chk_ph(ON_PHASE_A);
      evt_req = 2'b00;
      cyc(2);
      chk("out a", 4'h0, {3'b000, WAVEFORM_OUT_A});
      enter(DEAD_PHASE_B);
      enter(ON_PHASE_A);
      cyc(2);
      chk("out a", 4'h1, {3'b000, WAVEFORM_OUT_A});
      idle("mode9");
   endtask

   task automatic t_mode10;
      set_mode(`PWF_MODE_NONE, `PWF_MODE_LVL_BLK);
      evt_req = 2'b01;
      enter(ON_PHASE_A);
      cyc(2);
      chk("out a", 4'h0, {3'b000, WAVEFORM_OUT_A});
      evt_req = 2'b00;
      cyc(5);
      chk("out a", 4'h0, {3'b000, WAVEFORM_OUT_A});
      enter(ON_PHASE_A);
      cyc(2);
      chk("out a", 4'h1, {3'b000, WAVEFORM_OUT_A});
      idle("mode10");
   endtask

   // ----------------------------------------------------------------------
   // clock, watchdog and main sequence
   // ----------------------------------------------------------------------
   initial begin
      CLK_SYS = 1'b0;
      forever #2.5 CLK_SYS = ~CLK_SYS;
   end

   // whole run is about a thousand cycles; this is some twenty times that
   initial begin
      #100000;
      n_mismatch++;
      end_sim();
   end

   initial begin
      RSTN = 1'b0;
      TIMER_EN = 1'b0;
      RESTART_CMD = 1'b0;
      evt_req = 2'b00;
      evt_slow = 1'b0;
      FAULT_MODE_SELECT = '0;
      PHASE_LEN = '{dead_a: 12'h003, on_a: 12'h00b, dead_b: 12'h003, on_b: 12'h00b};
      cyc(20);
      RSTN = 1'b1;
      cyc(1);
      chk("reset outs", 4'h0, {1'b0, HALTED, WAVEFORM_OUT_A, WAVEFORM_OUT_B});
      TIMER_EN = 1'b1;
      t_mode0();
      t_mode1();
      t_mode2();
      t_mode3();
      t_mode4();
      t_mode5();
      t_mode6();
      t_mode7();
      t_mode8();
      t_mode9();
      t_mode10();
      end_sim();
   end
endmodule // pwf_fault_top_tb
